// ---- include/nip_consts.svh ----
`ifndef NIP_CONSTS_SVH
`define NIP_CONSTS_SVH

// Register addresses of the vector priority registers
`define NIP_ADDR_W 8
`define NIP_ADDR_PRIO0 8'h1c
`define NIP_ADDR_PRIO1 8'h1d
`define NIP_ADDR_PRIO2 8'h1e
`define NIP_ADDR_PRIO3 8'h1f
// Condition flags register, own choice of address
`define NIP_ADDR_FLAGS 8'h20
`define NIP_PRIO_RESET 8'hff
`define NIP_PRIO3_RO_MASK 8'hf0
// Condition flags layout and reset
`define NIP_FLAGS_RESET 8'hea
`define NIP_FLAGS_HI_BIT 5
`define NIP_FLAGS_LO_BIT 3
// Two-bit level codes, {high,low}
`define NIP_LVL0 2'h2
`define NIP_LVL1 2'h1
`define NIP_LVL2 2'h0
`define NIP_LVL3 2'h3
// Vector table
`define NIP_NUM_VEC 14
`define NIP_ADDR_RESET_VEC 16'hfffe
`define NIP_ADDR_TRAP_VEC 16'hfffc
`define NIP_ADDR_VEC0 16'hfffa
// Halt wake capability per maskable vector (bit k = vector k)
`define NIP_WAKE_MASK 14'h002b
// Vectors that are not implemented
`define NIP_UNUSED_MASK 14'h3300

`endif

// ---- include/nip_pkg.sv ----
package nip_pkg;

	// Kind of entry being taken
	typedef enum logic [2:0] {
		NIP_TAKE_NONE = 3'b001,
		NIP_TAKE_TRAP = 3'b010,
		NIP_TAKE_VEC = 3'b100
	} nip_take_t;

	// Source of a core write to the current-priority field
	typedef enum logic [1:0] {
		NIP_CPW_NONE = 2'h0,
		NIP_CPW_LOAD = 2'h1
	} nip_cpw_t;

endpackage

// ---- src/nip_ctrl.sv ----
// Summary of operation
// - Current priority at flag bits 5 and 3
// - Level 3 blocks maskable, trap still taken
// - Interrupt entry loads vector's stored priority
// - Core instructions may write priority field
// - Flags reset to 111x 1010
// - Four priority registers, reset to all ones
// - Fourth register upper nibble reads one
// - Register n holds vectors 4n to 4n+3
// - Writes of level 0 code are ignored
// - Reset and trap set level 3
// - Raised priority on pending vector re-enters
// - Fixed two-byte vector addresses, descending
// - Lower vector number wins equal priority
// - Per-vector wake-from-halt capability
// - External groups collect port pins, option swaps
// - Serviced only if enabled and above current
// - Highest software priority chosen first
// - Core stacks context, restores on return
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "nip_consts.svh"

module nip_ctrl
	import nip_pkg::*;
#(
	parameter int NUM_VEC = `NIP_NUM_VEC
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Pins of the external line groups
	input wire logic [7:0] port_a_pins_i,
	input wire logic [7:0] port_b_pins_i,
	input wire logic [5:0] port_c_pins_i,
	input wire logic [7:0] port_a_sel_i,
	input wire logic [7:0] port_b_sel_i,
	input wire logic [5:0] port_c_sel_i,
	input wire logic port_c_option_i,
	// Peripheral requests for vectors 2..13; enables and clears for all vectors 0..13
	input wire logic [NUM_VEC-1:0] periph_req_i,
	input wire logic [NUM_VEC-1:0] vec_enable_i,
	input wire logic [NUM_VEC-1:0] vec_ack_clear_i,
	// Core side
	input wire logic instr_boundary_i,
	input wire logic trap_i,
	input wire logic halted_i,
	input wire logic entry_ack_i,
	input wire logic prio_wr_i,
	input wire logic [1:0] prio_wdata_i,
	input wire logic [7:0] flags_in_i,
	output logic take_int_o,
	output logic [3:0] take_vec_o,
	output logic take_trap_o,
	output logic [15:0] take_addr_o,
	output logic wake_o,
	output logic [1:0] cur_prio_o,
	output logic [7:0] flags_o
);

	logic [7:0] prio_q [4];
	logic [7:0] flags_q;
	logic [NUM_VEC-1:0] pend_q;
	logic [7:0] pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
	logic [5:0] pc_s1_q, pc_s2_q;
	logic grp_a_q, grp_b_q;
	logic grp_a_lvl, grp_b_lvl;
	logic [NUM_VEC-1:0] raw_req;
	logic [1:0] vec_lvl [NUM_VEC];
	logic [2:0] vec_rank [NUM_VEC];
	logic [2:0] cur_rank;
	logic win_ok;
	logic [3:0] win_idx;
	logic [2:0] win_rank;
	logic [1:0] win_lvl;
	logic wake_any;
	logic [NUM_VEC-1:0] wake_mask;
	nip_take_t take_q;
	logic [3:0] vec_q;
	logic [15:0] addr_q;
	logic [7:0] rdata_d;

	// Two-flop synchronisers on the port pins
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pa_s1_q <= 8'hff;
			pa_s2_q <= 8'hff;
			pb_s1_q <= 8'hff;
			pb_s2_q <= 8'hff;
			pc_s1_q <= 6'h3f;
			pc_s2_q <= 6'h3f;
		end else begin
			pa_s1_q <= port_a_pins_i;
			pa_s2_q <= pa_s1_q;
			pb_s1_q <= port_b_pins_i;
			pb_s2_q <= pb_s1_q;
			pc_s1_q <= port_c_pins_i;
			pc_s2_q <= pc_s1_q;
		end
	end

	// Selected pins are NANDed: any selected pin low requests; option swaps in port C
	always_comb begin
		grp_a_lvl = ~&(pa_s2_q | ~port_a_sel_i);
		grp_b_lvl = ~&(pb_s2_q | ~port_b_sel_i);
		if (port_c_option_i) begin
			grp_a_lvl = ~&(pc_s2_q | ~port_c_sel_i);
		end
	end

	// Falling-to-active edge of each group latches a request
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grp_a_q <= 1'b0;
			grp_b_q <= 1'b0;
		end else begin
			grp_a_q <= grp_a_lvl;
			grp_b_q <= grp_b_lvl;
		end
	end

	// Raw requests; unused vectors never request
	always_comb begin
		raw_req = periph_req_i & ~NUM_VEC'(`NIP_UNUSED_MASK);
		raw_req[0] = grp_a_lvl & ~grp_a_q;
		raw_req[1] = grp_b_lvl & ~grp_b_q;
	end

	// Pending latch: request setting wins over clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= '0;
		end else begin
			pend_q <= (pend_q & ~vec_ack_clear_i) | raw_req;
		end
	end

	// Map level codes to ranks 0..3 so levels compare numerically
	function automatic logic [2:0] lvl_rank(input logic [1:0] code);
		case (code)
			`NIP_LVL0: lvl_rank = 3'h0;
			`NIP_LVL1: lvl_rank = 3'h1;
			`NIP_LVL2: lvl_rank = 3'h2;
			default: lvl_rank = 3'h3;
		endcase
	endfunction

	// Per-vector stored level taken from its register bit pair
	genvar gv;
	generate
		for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
			assign vec_lvl[gv] = prio_q[gv/4][2*(gv%4) +: 2];
			assign vec_rank[gv] = lvl_rank(vec_lvl[gv]);
		end
	endgenerate

	assign cur_rank = lvl_rank({flags_q[`NIP_FLAGS_HI_BIT], flags_q[`NIP_FLAGS_LO_BIT]});

	// Wake capability as a vector so each bit is picked by index, not by shifting a literal
	assign wake_mask = NUM_VEC'(`NIP_WAKE_MASK);

	// Arbitration: highest rank, ties to the lower vector; halted core sees only waking vectors
	always_comb begin
		win_ok = 1'b0;
		win_idx = 4'h0;
		win_rank = 3'h0;
		win_lvl = `NIP_LVL3;
		wake_any = 1'b0;
		for (int k = 0; k < NUM_VEC; k++) begin
			if (pend_q[k] && vec_enable_i[k] && vec_rank[k] > cur_rank) begin
				if (!halted_i || wake_mask[k]) begin
					if (!win_ok || vec_rank[k] > win_rank) begin
						win_ok = 1'b1;
						win_idx = 4'(k);
						win_rank = vec_rank[k];
						win_lvl = vec_lvl[k];
					end
				end
			end
			if (pend_q[k] && vec_enable_i[k] && wake_mask[k]) begin
				wake_any = 1'b1;
			end
		end
	end

	// Take request held until the core acknowledges entry; trap ranks above all
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			take_q <= NIP_TAKE_NONE;
			vec_q <= 4'h0;
			addr_q <= `NIP_ADDR_RESET_VEC;
		end else begin
			case (take_q)
				NIP_TAKE_NONE: begin
					if (instr_boundary_i && trap_i) begin
						take_q <= NIP_TAKE_TRAP;
						addr_q <= `NIP_ADDR_TRAP_VEC;
					end else if (instr_boundary_i && win_ok) begin
						take_q <= NIP_TAKE_VEC;
						vec_q <= win_idx;
						addr_q <= `NIP_ADDR_VEC0 - {11'h0, win_idx, 1'b0};
					end
				end
				NIP_TAKE_TRAP, NIP_TAKE_VEC: begin
					if (entry_ack_i) begin
						take_q <= NIP_TAKE_NONE;
					end
				end
				default: take_q <= NIP_TAKE_NONE;
			endcase
		end
	end

	assign take_int_o = (take_q == NIP_TAKE_VEC) || (take_q == NIP_TAKE_TRAP);
	assign take_trap_o = (take_q == NIP_TAKE_TRAP);
	assign take_vec_o = vec_q;
	assign take_addr_o = addr_q;
	assign wake_o = wake_any || trap_i;

	// Condition flags; entry loads the priority, which re-evaluates nesting at once
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= `NIP_FLAGS_RESET;
		end else if (entry_ack_i && take_q == NIP_TAKE_TRAP) begin
			flags_q[`NIP_FLAGS_HI_BIT] <= 1'b1;
			flags_q[`NIP_FLAGS_LO_BIT] <= 1'b1;
		end else if (entry_ack_i && take_q == NIP_TAKE_VEC) begin
			// Level captured from the live register so a raised level re-enters
			flags_q[`NIP_FLAGS_HI_BIT] <= vec_lvl[vec_q][1];
			flags_q[`NIP_FLAGS_LO_BIT] <= vec_lvl[vec_q][0];
		end else if (prio_wr_i) begin
			// Mask, unmask, halt, wait, return and pop all land here
			flags_q <= flags_in_i;
			flags_q[`NIP_FLAGS_HI_BIT] <= prio_wdata_i[1];
			flags_q[`NIP_FLAGS_LO_BIT] <= prio_wdata_i[0];
		end
	end

	assign flags_o = flags_q;
	assign cur_prio_o = {flags_q[`NIP_FLAGS_HI_BIT], flags_q[`NIP_FLAGS_LO_BIT]};

	// Priority registers: level-0 code pairs keep old value
	generate
		for (gv = 0; gv < 4; gv++) begin : g_reg
			logic [7:0] wr_d;
			always_comb begin
				wr_d = prio_q[gv];
				for (int p = 0; p < 4; p++) begin
					if (reg_wdata_i[2*p +: 2] != `NIP_LVL0) begin
						wr_d[2*p +: 2] = reg_wdata_i[2*p +: 2];
					end
				end
				if (gv == 3) begin
					wr_d = wr_d | `NIP_PRIO3_RO_MASK;
				end
			end
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					prio_q[gv] <= `NIP_PRIO_RESET;
				end else if (reg_wr_i && reg_addr_i == `NIP_ADDR_PRIO0 + 8'(gv)) begin
					prio_q[gv] <= wr_d;
				end
			end
		end
	endgenerate

	// Read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr_i)
			`NIP_ADDR_PRIO0: rdata_d = prio_q[0];
			`NIP_ADDR_PRIO1: rdata_d = prio_q[1];
			`NIP_ADDR_PRIO2: rdata_d = prio_q[2];
			`NIP_ADDR_PRIO3: rdata_d = prio_q[3];
			`NIP_ADDR_FLAGS: rdata_d = flags_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_d;
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// ---- testbench/nip_ctrl_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module nip_ctrl_chk #(
	parameter int NUM_VEC = 14
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic entry_ack_i,
	input wire logic take_int_o,
	input wire logic take_trap_o,
	input wire logic [3:0] take_vec_o,
	input wire logic [15:0] take_addr_o,
	input wire logic [1:0] cur_prio_o,
	input wire logic [7:0] flags_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Entry handshake: a standing take meets the core's acknowledge
	sequence s_ack;
		take_int_o && entry_ack_i;
	endsequence
	// Read strobe on the upper priority register one cycle back
	sequence s_rd_top;
		$past(reg_rd_i) && $past(reg_addr_i) == 8'h1f;
	endsequence
	chk_flags_reset: assert property ($rose(rst_n_i) |-> flags_o == 8'hea)
		else $error("flags not at reset value");
	chk_prio_bits: assert property (cur_prio_o == {flags_o[5], flags_o[3]})
		else $error("priority field off its flag bits");
	chk_trap_level: assert property (s_ack ##0 take_trap_o |=> cur_prio_o == 2'h3)
		else $error("trap entry did not set level 3");
	chk_take_hold: assert property (take_int_o && !entry_ack_i |=> take_int_o && $stable(take_addr_o))
		else $error("take dropped before acknowledge");
	chk_ack_drop: assert property (s_ack |=> !take_int_o)
		else $error("take stands after acknowledge");
	chk_vec_addr: assert property (take_int_o && !take_trap_o |-> take_addr_o == 16'hfffa - {take_vec_o, 1'b0})
		else $error("vector address wrong");
	chk_trap_addr: assert property (take_int_o && take_trap_o |-> take_addr_o == 16'hfffc)
		else $error("trap address wrong");
	chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	chk_top_nibble: assert property (s_rd_top |-> reg_rdata_o[7:4] == 4'hf)
		else $error("upper nibble not one");
	chk_level3_block: assert property ($rose(take_int_o) && !take_trap_o |-> $past(cur_prio_o) != 2'h3)
		else $error("maskable taken at level 3");
endmodule
bind nip_ctrl nip_ctrl_chk #(.NUM_VEC(NUM_VEC)) u_chk (.*);
`default_nettype wire

// ---- testbench/nip_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module nip_core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic slow_i,
	input wire logic take_int_i,
	output logic boundary_o,
	output logic ack_o
);
	logic [1:0] wait_q;
	// Boundaries only while running; slow mode stretches stacking to test the hold
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boundary_o <= 1'b0;
			ack_o <= 1'b0;
			wait_q <= 2'h0;
		end else begin
			boundary_o <= run_i && !take_int_i && !ack_o;
			ack_o <= take_int_i && !ack_o && wait_q >= (slow_i ? 2'h2 : 2'h0);
			wait_q <= (take_int_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "nip_consts.svh"
module testbench;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, pwr = 0, trap = 0, run = 0, slow = 0;
	logic [7:0] addr = 0, wd = 0, rdat, flg, pa = 8'hff, sel = 8'h01, fin = 0;
	logic [13:0] req = 0, clr = 0, pend = 0, en = 14'h3fff;
	logic [1:0] pw = 0, cur, cp;
	logic [7:0] rm [4];
	logic ti, tt, bnd, ack, wk;
	logic [3:0] tv;
	logic [15:0] ta;
	int bad_count = 0, checks_done = 0;
	// Free-running core clock
	always #10 clk = ~clk;
	nip_ctrl dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .port_a_pins_i(pa),
		.port_b_pins_i(pa), .port_c_pins_i(pa[5:0]), .port_a_sel_i(sel), .port_b_sel_i(8'h00),
		.port_c_sel_i(6'h00), .port_c_option_i(1'b0), .periph_req_i(req), .vec_enable_i(en),
		.vec_ack_clear_i(clr), .instr_boundary_i(bnd), .trap_i(trap), .halted_i(1'b0),
		.entry_ack_i(ack), .prio_wr_i(pwr), .prio_wdata_i(pw), .flags_in_i(fin),
		.take_int_o(ti), .take_vec_o(tv), .take_trap_o(tt), .take_addr_o(ta), .wake_o(wk),
		.cur_prio_o(cp), .flags_o(flg));
	nip_core_model core (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .slow_i(slow),
		.take_int_i(ti), .boundary_o(bnd), .ack_o(ack));
	// Compare and count
	task chk(string n, logic [15:0] s, logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	task summarize();
		if (bad_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Register writes update the model; level 0 codes are refused pair by pair
	task wrt(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		for (int p = 0; p < 8; p += 2)
			if (d[p+:2] != `NIP_LVL0) rm[a[1:0]][p+:2] = d[p+:2];
		rm[3][7:4] = 4'hf;
	endtask
	task rdc(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk("rdata", rdat, e);
	endtask
	// Core loads the whole flags byte, as a return or mask instruction would
	task cw(logic [1:0] c);
		@(posedge clk);
		pwr <= 1;
		pw <= c;
		fin <= {2'b11, c[1], 1'b0, c[0], 3'b010};
		@(posedge clk);
		pwr <= 0;
		cur = c;
		#1 chk("cur_prio", cp, c);
		chk("flags", {flg[5], flg[3]}, c);
	endtask
	task pulse(bit set, int v);
		@(posedge clk);
		if (set) req <= 14'(1) << v;
		else clr <= 14'(1) << v;
		@(posedge clk);
		req <= 0;
		clr <= 0;
		pend[v] = set;
	endtask
	function logic [1:0] pc(int k);
		return rm[k/4][2*(k%4)+:2];
	endfunction
	function int lv(logic [1:0] c);
		return c == 3 ? 3 : c == 2 ? 0 : 2 - c;
	endfunction
	// Model arbitration: trap first, then highest level above current, lower index on ties
	function int win();
		int b;
		b = -1;
		if (trap) return 14;
		for (int k = 0; k < 14; k++)
			if (pend[k] && lv(pc(k)) > lv(cur) && (b < 0 || lv(pc(k)) > lv(pc(b)))) b = k;
		return b;
	endfunction
	task go();
		int v, n;
		v = win();
		n = 0;
		run <= 1;
		slow <= 1'($urandom % 2);
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ti !== 1 && n < 30);
		chk("wake", wk, trap || (pend & 14'(`NIP_WAKE_MASK)) != 0);
		run <= 0;
		chk("take", ti, v >= 0);
		if (v >= 0 && ti !== 1) summarize();
		if (v >= 0) begin
			trap <= 0;
			chk("addr", ta, v == 14 ? 16'hfffc : 16'hfffa - 16'(2 * v));
			chk("trap", tt, v == 14);
			if (v < 14) chk("vec", tv, 16'(v));
			n = 0;
			while (ti !== 0 && n < 30) begin
				@(posedge clk);
				#1;
				n++;
			end
			if (ti !== 0) begin
				bad_count++;
				summarize();
			end
			cur = v == 14 ? 2'h3 : pc(v);
			chk("cur_prio", cp, cur);
		end
	endtask
	initial begin
		logic [7:0] x;
		rm = '{default: 8'hff};
		cur = 2'h3;
		void'($urandom(73));
		repeat (20) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		#1 chk("flags", flg, 8'hea);
		for (int a = 0; a < 4; a++) rdc(8'h1c + 8'(a), 8'hff);
		rdc(8'h20, 8'hea);
		rdc(8'h30, 8'h00);
		wrt(8'h1c, 8'hcf);
		wrt(8'h1c, 8'h64);
		rdc(8'h1c, 8'h44);
		repeat (12) begin
			x = 8'h1c + 8'($urandom % 4);
			wrt(x, 8'($urandom));
			rdc(x, rm[x[1:0]]);
		end
		wrt(8'h1c, 8'h4d);
		wrt(8'h1d, 8'hfd);
		cw(`NIP_LVL0);
		pulse(1, 2);
		pulse(1, 4);
		go();
		pulse(0, 2);
		cw(`NIP_LVL0);
		go();
		wrt(8'h1d, 8'hfc);
		go();
		pulse(0, 4);
		cw(`NIP_LVL0);
		@(posedge clk);
		pa <= 8'hfe;
		repeat (4) @(posedge clk);
		pa <= 8'hff;
		pend[0] = 1;
		pulse(1, 3);
		go();
		pulse(0, 0);
		go();
		cw(`NIP_LVL0);
		go();
		pulse(0, 3);
		cw(`NIP_LVL3);
		pulse(1, 2);
		go();
		@(posedge clk);
		trap <= 1;
		@(posedge clk);
		go();
		go();
		cw(`NIP_LVL0);
		go();
		summarize();
	end
endmodule
`default_nettype wire
